// ===== encoder_parameter_command_unit.v
// Command interpreter of the encoder parameter channel
`include "param_cmd_map.vh"
module encoder_parameter_command_unit #(
    parameter BIT_CYCLES = `BIT_CYCLES,
    parameter NUM_FIELDS = 8,
    parameter FIELD_BYTES = 16,
    // Arbitrary identification values
    parameter [7:0] MODEL_ID = 8'h5A,
    parameter [31:0] SERIAL_NO = 32'h00000001,
    parameter [7:0] PROG_VERSION = 8'h01
) (
    input wire core_clk,
    input wire rst,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_parity_err,
    input wire rx_end,
    input wire [26:0] raw_position,
    input wire [5:0] init_fault,
    input wire watchdog_reset,
    input wire speed_high,
    input wire singleturn_bad,
    input wire [2:0] multiturn_fault,
    input wire analog_mon_fault,
    input wire current_fault,
    input wire temp_fault,
    output wire line_out,
    output wire line_oe,
    output reg [7:0] fault_code,
    output reg [7:0] node_addr,
    output reg [7:0] iface_mode,
    output reg busy
);
    localparam FW = $clog2(NUM_FIELDS);
    localparam OW = $clog2(FIELD_BYTES);
    localparam [1:0] S_RX = 2'h0;
    localparam [1:0] S_EXEC = 2'h1;
    localparam [1:0] S_TX = 2'h2;

    reg [1:0] state;
    reg [7:0] rxb [0:`RX_BUF_BYTES-1];
    reg [7:0] txb [0:`RX_BUF_BYTES-1];
    reg [3:0] rx_cnt;
    reg [7:0] rx_xor;
    reg rx_par;
    reg [3:0] tx_len;
    reg [3:0] tx_idx;
    reg [7:0] tx_xor;
    reg tx_go;
    reg [7:0] tx_byte;
    reg [7:0] code0;
    reg [26:0] pos_offset;
    reg [7:0] mem [0:NUM_FIELDS*FIELD_BYTES-1];
    reg [7:0] fld_size [0:NUM_FIELDS-1];
    reg [7:0] fld_code [0:NUM_FIELDS-1];
    reg [NUM_FIELDS-1:0] fld_exist;
    reg [7:0] err;
    reg [7:0] free_bytes;
    reg [7:0] hw_code;
    wire tx_busy;
    integer i;

    wire [7:0] cmd = rxb[1];
    wire [FW-1:0] fld = rxb[2][FW-1:0];
    wire fld_ok = rxb[2] < NUM_FIELDS;
    wire [FW+OW-1:0] mem_idx = {fld, rxb[3][OW-1:0]};
    wire addressed = rxb[0] == node_addr;
    wire [26:0] position = raw_position + pos_offset;
    wire [26:0] new_pos = {rxb[2][2:0], rxb[3], rxb[4], rxb[5]};

    // Number of argument bytes between command and checksum
    function [3:0] arg_count;
        input [7:0] c;
        begin
            case (c)
                `CMD_READ_POS, `CMD_FREE_MEM, `CMD_READ_STATUS: arg_count = 4'h0;
                `CMD_TYPE_LABEL, `CMD_ENC_RESET, `CMD_SERIAL: arg_count = 4'h0;
                `CMD_SET_POS: arg_count = 4'h5;
                `CMD_READ_DATA, `CMD_CREATE_FIELD, `CMD_CHANGE_CODE: arg_count = 4'h3;
                `CMD_STORE_DATA: arg_count = 4'h4;
                `CMD_FIELD_STATUS: arg_count = 4'h1;
                `CMD_SET_ADDR, `CMD_CFG_IFACE: arg_count = 4'h2;
                default: arg_count = `ARGS_UNKNOWN;
            endcase
        end
    endfunction

    // Fault inputs to status code, priority init, watchdog, speed, singleturn, multiturn, analog monitor, current, temp
    always @* begin
        hw_code = `ST_OK;
        if (temp_fault) hw_code = `ST_TEMP;
        if (current_fault) hw_code = `ST_CURRENT;
        if (analog_mon_fault) hw_code = `ST_ANALOG_MON;
        for (i = 2; i >= 0; i = i - 1) begin
            if (multiturn_fault[i]) hw_code = `ST_MT_BASE + i[7:0];
        end
        if (singleturn_bad) hw_code = `ST_SINGLETURN;
        if (speed_high) hw_code = `ST_SPEED;
        if (watchdog_reset) hw_code = `ST_WATCHDOG;
        for (i = 5; i >= 0; i = i - 1) begin
            if (init_fault[i]) hw_code = `ST_INIT_BASE + i[7:0];
        end
    end

    always @* begin
        free_bytes = 8'h00;
        for (i = 0; i < NUM_FIELDS; i = i + 1) begin
            if (!fld_exist[i]) free_bytes = free_bytes + FIELD_BYTES[7:0];
        end
    end

    // Frame and command checks
    always @* begin
        err = `ST_OK;
        if (rx_par) err = `ST_PARITY;
        else if (arg_count(cmd) == `ARGS_UNKNOWN) err = `ST_UNKNOWN;
        else if (rx_cnt != arg_count(cmd) + `FRAME_OVERHEAD) err = `ST_COUNT;
        else if (rx_xor != 8'h00) err = `ST_CHECKSUM;
        else begin
            case (cmd)
                `CMD_SET_POS: if (rxb[6] != code0) err = `ST_ACCESS;
                `CMD_SET_ADDR, `CMD_CFG_IFACE: if (rxb[3] != code0) err = `ST_ACCESS;
                `CMD_READ_DATA, `CMD_STORE_DATA, `CMD_FIELD_STATUS, `CMD_CREATE_FIELD, `CMD_CHANGE_CODE: begin
                    if (cmd == `CMD_CHANGE_CODE && rxb[2] == `CODE0_FIELD) begin
                        if (rxb[3] != code0) err = `ST_ACCESS;
                    end else if (!fld_ok) err = `ST_ARG;
                    else if (cmd == `CMD_CREATE_FIELD) begin
                        if (fld_exist[fld]) err = `ST_RESIZE;
                        else if (rxb[3][6:0] == 7'h00 || rxb[3][6:0] > FIELD_BYTES) err = `ST_ARG;
                    end else if (!fld_exist[fld]) err = `ST_MISSING;
                    else if (cmd == `CMD_CHANGE_CODE && rxb[3] != fld_code[fld]) err = `ST_ACCESS;
                    else if ((cmd == `CMD_READ_DATA || cmd == `CMD_STORE_DATA) && rxb[4] != fld_code[fld])
                        err = `ST_ACCESS;
                    else if ((cmd == `CMD_READ_DATA || cmd == `CMD_STORE_DATA) && rxb[3] >= fld_size[fld][6:0])
                        err = `ST_ADDR;
                    else if (cmd == `CMD_STORE_DATA && fld_size[fld][`PROT_BIT]) err = `ST_PROTECT;
                end
                default: err = `ST_OK;
            endcase
        end
    end

    // latest fault held, set wins over clear
    always @(posedge core_clk) begin
        if (rst) begin
            fault_code <= `ST_OK;
        end else if (hw_code != `ST_OK) begin
            fault_code <= hw_code;
        end else if (state == S_EXEC && addressed && err != `ST_OK) begin
            fault_code <= err;
        end else if (state == S_EXEC && addressed && cmd == `CMD_ENC_RESET) begin
            fault_code <= `ST_OK;
        end
    end

    always @(posedge core_clk) begin
        tx_go <= 1'b0;
        if (rst) begin
            state <= S_RX;
            rx_cnt <= 4'h0;
            rx_xor <= 8'h00;
            rx_par <= 1'b0;
            tx_len <= 4'h0;
            tx_idx <= 4'h0;
            tx_xor <= 8'h00;
            tx_byte <= 8'h00;
            code0 <= `RST_CODE0;
            pos_offset <= 27'h0;
            fld_exist <= {NUM_FIELDS{1'b0}};
            node_addr <= `RST_NODE_ADDR;
            iface_mode <= `RST_IFACE_MODE;
            busy <= 1'b0;
        end else begin
            case (state)
                S_RX: begin
                    if (rx_valid) begin
                        if (rx_cnt < `RX_BUF_BYTES) rxb[rx_cnt[2:0]] <= rx_data;
                        if (rx_cnt != 4'hF) rx_cnt <= rx_cnt + 4'h1;
                        rx_xor <= rx_xor ^ rx_data;
                        rx_par <= rx_par | rx_parity_err;
                    end else if (rx_end && rx_cnt != 4'h0) begin
                        state <= S_EXEC;
                        busy <= 1'b1;
                    end
                end
                S_EXEC: begin
                    txb[0] <= node_addr;
                    txb[1] <= (err != `ST_OK) ? (cmd | `ERR_FLAG) : cmd;
                    tx_len <= 4'h2;
                    if (err != `ST_OK) begin
                        txb[2] <= err;
                        tx_len <= 4'h3;
                    end else begin
                        case (cmd)
                            `CMD_READ_POS: begin
                                txb[2] <= {5'h00, position[26:24]};
                                txb[3] <= position[23:16];
                                txb[4] <= position[15:8];
                                txb[5] <= position[7:0];
                                tx_len <= 4'h6;
                            end
                            `CMD_SET_POS: pos_offset <= new_pos - raw_position;
                            `CMD_READ_DATA: begin
                                txb[2] <= mem[mem_idx];
                                tx_len <= 4'h3;
                            end
                            `CMD_STORE_DATA: mem[mem_idx] <= rxb[5];
                            `CMD_FIELD_STATUS: begin
                                txb[2] <= fld_size[fld];
                                tx_len <= 4'h3;
                            end
                            `CMD_CREATE_FIELD: begin
                                fld_exist[fld] <= 1'b1;
                                fld_size[fld] <= rxb[3];
                                fld_code[fld] <= rxb[4];
                            end
                            `CMD_FREE_MEM: begin
                                txb[2] <= free_bytes;
                                tx_len <= 4'h3;
                            end
                            `CMD_CHANGE_CODE: begin
                                if (rxb[2] == `CODE0_FIELD) code0 <= rxb[4];
                                else fld_code[fld] <= rxb[4];
                            end
                            `CMD_READ_STATUS: begin
                                txb[2] <= fault_code;
                                tx_len <= 4'h3;
                            end
                            `CMD_TYPE_LABEL: begin
                                txb[2] <= MODEL_ID;
                                tx_len <= 4'h3;
                            end
                            `CMD_SET_ADDR: node_addr <= rxb[2];
                            `CMD_SERIAL: begin
                                txb[2] <= SERIAL_NO[31:24];
                                txb[3] <= SERIAL_NO[23:16];
                                txb[4] <= SERIAL_NO[15:8];
                                txb[5] <= SERIAL_NO[7:0];
                                txb[6] <= PROG_VERSION;
                                tx_len <= 4'h7;
                            end
                            `CMD_CFG_IFACE: iface_mode <= rxb[2];
                            default: tx_len <= 4'h2;
                        endcase
                    end
                    rx_cnt <= 4'h0;
                    rx_xor <= 8'h00;
                    rx_par <= 1'b0;
                    tx_idx <= 4'h0;
                    tx_xor <= 8'h00;
                    if (addressed) begin
                        state <= S_TX;
                    end else begin
                        state <= S_RX;
                        busy <= 1'b0;
                    end
                end
                S_TX: begin
                    if (!tx_busy && !tx_go) begin
                        if (tx_idx < tx_len) begin
                            tx_byte <= txb[tx_idx[2:0]];
                            tx_xor <= tx_xor ^ txb[tx_idx[2:0]];
                            tx_go <= 1'b1;
                            tx_idx <= tx_idx + 4'h1;
                        end else if (tx_idx == tx_len) begin
                            tx_byte <= tx_xor;
                            tx_go <= 1'b1;
                            tx_idx <= tx_idx + 4'h1;
                        end else begin
                            state <= S_RX;
                            busy <= 1'b0;
                        end
                    end
                end
                default: state <= S_RX;
            endcase
        end
    end

    rs485_byte_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .core_clk(core_clk),
        .rst(rst),
        .go(tx_go),
        .data(tx_byte),
        .line_out(line_out),
        .line_oe(line_oe),
        .busy(tx_busy)
    );
endmodule // encoder_parameter_command_unit

// ===== param_cmd_map.vh
// Command codes, status codes, reset values and timing for the parameter command unit
`ifndef PARAM_CMD_MAP_VH
`define PARAM_CMD_MAP_VH

`define CLK_HZ 50000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)

`define CMD_READ_POS 8'h42
`define CMD_SET_POS 8'h43
`define CMD_READ_DATA 8'h4A
`define CMD_STORE_DATA 8'h4B
`define CMD_FIELD_STATUS 8'h4C
`define CMD_CREATE_FIELD 8'h4D
`define CMD_FREE_MEM 8'h4E
`define CMD_CHANGE_CODE 8'h4F
`define CMD_READ_STATUS 8'h50
`define CMD_TYPE_LABEL 8'h52
`define CMD_ENC_RESET 8'h53
`define CMD_SET_ADDR 8'h55
`define CMD_SERIAL 8'h56
`define CMD_CFG_IFACE 8'h57

`define ARGS_UNKNOWN 4'hF
`define FRAME_OVERHEAD 4'h3
`define RX_BUF_BYTES 8
`define ERR_FLAG 8'h80
`define PROT_BIT 7
`define CODE0_FIELD 8'hFF

`define ST_OK 8'h00
`define ST_INIT_BASE 8'h01
`define ST_WATCHDOG 8'h07
`define ST_PARITY 8'h09
`define ST_CHECKSUM 8'h0A
`define ST_UNKNOWN 8'h0B
`define ST_COUNT 8'h0C
`define ST_ARG 8'h0D
`define ST_PROTECT 8'h0E
`define ST_ACCESS 8'h0F
`define ST_RESIZE 8'h10
`define ST_ADDR 8'h11
`define ST_MISSING 8'h12
`define ST_ANALOG_MON 8'h1C
`define ST_CURRENT 8'h1D
`define ST_TEMP 8'h1E
`define ST_SPEED 8'h1F
`define ST_SINGLETURN 8'h20
`define ST_MT_BASE 8'h21

`define RST_NODE_ADDR 8'h40
`define RST_IFACE_MODE 8'hE4
`define RST_CODE0 8'h55
`define POS_BITS 27

`endif

// ===== rs485_byte_tx.v
// Serialises one byte with even parity onto the half-duplex line and drives its enable
`include "param_cmd_map.vh"
module rs485_byte_tx #(
    parameter BIT_CYCLES = `BIT_CYCLES
) (
    input wire core_clk,
    input wire rst,
    input wire go,
    input wire [7:0] data,
    output reg line_out,
    output reg line_oe,
    output reg busy
);
    reg [10:0] shift;
    reg [3:0] bits_left;
    reg [31:0] bit_cnt;

    always @(posedge core_clk) begin
        if (rst) begin
            shift <= 11'h7FF;
            bits_left <= 4'h0;
            bit_cnt <= 32'h0;
            line_out <= 1'b1;
            line_oe <= 1'b0;
            busy <= 1'b0;
        end else if (!busy) begin
            line_oe <= 1'b0;
            line_out <= 1'b1;
            if (go) begin
                // Stop, even parity, data LSB first, start
                shift <= {1'b1, ^data, data, 1'b0};
                bits_left <= 4'hB;
                bit_cnt <= 32'h0;
                busy <= 1'b1;
            end
        end else begin
            line_oe <= 1'b1;
            line_out <= shift[0];
            if (bit_cnt == BIT_CYCLES - 1) begin
                bit_cnt <= 32'h0;
                shift <= {1'b1, shift[10:1]};
                bits_left <= bits_left - 4'h1;
                if (bits_left == 4'h1) begin
                    busy <= 1'b0;
                end
            end else begin
                bit_cnt <= bit_cnt + 32'h1;
            end
        end
    end
endmodule // rs485_byte_tx

// ===== encoder_parameter_command_unit_monitor.sv
// Port-level assertion checker for the parameter command unit
module encoder_parameter_command_unit_monitor #(
    parameter BIT_CYCLES = 8
) (
    input wire core_clk,
    input wire rst,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_parity_err,
    input wire rx_end,
    input wire [26:0] raw_position,
    input wire [5:0] init_fault,
    input wire watchdog_reset,
    input wire speed_high,
    input wire singleturn_bad,
    input wire [2:0] multiturn_fault,
    input wire analog_mon_fault,
    input wire current_fault,
    input wire temp_fault,
    input wire line_out,
    input wire line_oe,
    input wire [7:0] fault_code,
    input wire [7:0] node_addr,
    input wire [7:0] iface_mode,
    input wire busy
);
    reg took;
    wire hw_other;
    assign hw_other = |{init_fault, watchdog_reset, speed_high, singleturn_bad, multiturn_fault,
                        analog_mon_fault, current_fault};
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Remembers that the open frame holds at least one byte
    always @(posedge core_clk) begin
        if (rst || (rx_end && !busy)) begin
            took <= 1'b0;
        end else if (rx_valid && !busy) begin
            took <= 1'b1;
        end
    end
    a_line_idle_high:
        assert property (!line_oe |-> line_out) else $error("line not high while released");
    a_drive_while_busy:
        assert property (line_oe |-> busy) else $error("line driven while not busy");
    a_busy_after_end:
        assert property (rx_end && !busy && took |=> busy) else $error("busy missing after frame end");
    a_reply_bounded:
        assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("reply never finished");
    a_reset_values:
        assert property ($fell(rst) |-> node_addr == 8'h40 && iface_mode == 8'hE4 && !busy && !line_oe)
            else $error("wrong values after reset");
    a_init_code:
        assert property (init_fault[0] |=> fault_code == 8'h01) else $error("init fault code wrong");
    a_watchdog_code:
        assert property (watchdog_reset && init_fault == 6'h00 |=> fault_code == 8'h07)
            else $error("watchdog code wrong");
    a_speed_code:
        assert property (speed_high && init_fault == 6'h00 && !watchdog_reset |=> fault_code == 8'h1F)
            else $error("speed code wrong");
    a_temp_code:
        assert property (temp_fault && !hw_other |=> fault_code == 8'h1E) else $error("temperature code wrong");
    a_fault_held:
        assert property (!busy && !rx_end && !hw_other && !temp_fault |=> $stable(fault_code))
            else $error("fault code changed while idle");
endmodule // encoder_parameter_command_unit_monitor

bind encoder_parameter_command_unit encoder_parameter_command_unit_monitor #(.BIT_CYCLES(BIT_CYCLES))
    encoder_parameter_command_unit_monitor_inst (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_end(rx_end), .raw_position(raw_position),
    .init_fault(init_fault), .watchdog_reset(watchdog_reset), .speed_high(speed_high),
    .singleturn_bad(singleturn_bad), .multiturn_fault(multiturn_fault), .analog_mon_fault(analog_mon_fault),
    .current_fault(current_fault), .temp_fault(temp_fault), .line_out(line_out), .line_oe(line_oe),
    .fault_code(fault_code), .node_addr(node_addr), .iface_mode(iface_mode), .busy(busy));

// ===== drive_master_model.sv
// Drive controller model: sends command frames and decodes reply characters
module drive_master_model #(
    parameter BIT_CYCLES = 8
) (
    input wire core_clk,
    input wire line_out,
    input wire line_oe,
    output logic rx_valid = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_parity_err = 1'b0,
    output logic rx_end = 1'b0
);
    event byte_done;
    logic [7:0] got_byte;
    logic par_ok;
    logic [9:0] sh;
    task automatic send_frame(input logic [7:0] b[$], input int pe);
        foreach (b[i]) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = b[i];
            rx_parity_err = (i == pe);
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_parity_err = 1'b0;
        rx_data = ~rx_data;
        rx_end = 1'b1;
        @(negedge core_clk);
        rx_end = 1'b0;
    endtask
    always begin
        @(negedge core_clk);
        if (line_oe === 1'b1 && line_out === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(negedge core_clk);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYCLES) @(negedge core_clk);
                sh[i] = line_out;
            end
            got_byte = sh[7:0];
            par_ok = ~^sh[8:0] & sh[9];
            -> byte_done;
        end
    end
endmodule // drive_master_model

// ===== test_encoder_parameter_command_unit.sv
// Self-checking bench for the parameter command unit
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_encoder_parameter_command_unit;
    timeunit 1ns;
    timeprecision 100ps;
    localparam BITS = 8;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [26:0] raw_position = 27'h0;
    logic [14:0] fvec = 15'h0;
    logic skip = 1'b0;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'hF4DC;
    logic [26:0] pos;
    logic [7:0] last;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    wire rx_valid, rx_parity_err, rx_end, line_out, line_oe, busy;
    wire [7:0] rx_data, fault_code, node_addr, iface_mode;
    encoder_parameter_command_unit #(.BIT_CYCLES(BITS), .NUM_FIELDS(8), .FIELD_BYTES(16),
        .MODEL_ID(8'h5A), .SERIAL_NO(32'h00000001), .PROG_VERSION(8'h01)) encoder_parameter_command_unit_inst (
        .core_clk(core_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
        .rx_end(rx_end), .raw_position(raw_position), .init_fault(fvec[5:0]), .watchdog_reset(fvec[6]),
        .speed_high(fvec[7]), .singleturn_bad(fvec[8]), .multiturn_fault(fvec[11:9]),
        .analog_mon_fault(fvec[12]), .current_fault(fvec[13]), .temp_fault(fvec[14]), .line_out(line_out),
        .line_oe(line_oe), .fault_code(fault_code), .node_addr(node_addr), .iface_mode(iface_mode), .busy(busy));
    drive_master_model #(.BIT_CYCLES(BITS)) drive_master_model_inst (.core_clk(core_clk), .line_out(line_out),
        .line_oe(line_oe), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_end(rx_end));
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Status code expected for fault input number i
    function automatic logic [7:0] fcode(input int i);
        if (i < 6) return 8'(i + 1);
        if (i == 6) return 8'h07;
        if (i < 12) return 8'(8'h18 + i);
        return 8'(8'h10 + i);
    endfunction
    task automatic exp(input logic [7:0] r[$]);
        logic [7:0] c;
        c = 8'h00;
        foreach (r[i]) begin
            expq.push_back(r[i]);
            c ^= r[i];
        end
        expq.push_back(c);
    endtask
    task automatic exp_pos(input logic [7:0] a, input logic [26:0] p);
        exp('{a, 8'h42, {5'b0, p[26:24]}, p[23:16], p[15:8], p[7:0]});
    endtask
    task automatic run(input logic [7:0] b[$], input bit bad, input int pe);
        logic [7:0] c;
        int n;
        c = 8'h00;
        foreach (b[i]) c ^= b[i];
        b.push_back(bad ? ~c : c);
        drive_master_model_inst.send_frame(b, pe);
        n = 0;
        while (busy !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("busy_end", 1'b0, busy)
        repeat (4) @(negedge core_clk);
        `CHK("pending", 0, expq.size())
    endtask
    task automatic err(input logic [7:0] b[$], input bit bad, input int pe, input logic [7:0] code);
        exp('{8'h40, b[1] | 8'h80, code});
        run(b, bad, pe);
        `CHK("fault_code", code, fault_code)
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    initial begin
        forever begin
            @(drive_master_model_inst.byte_done);
            if (!skip) begin
                if (expq.size() == 0) begin
                    mismatches++;
                    $display("CHECK FAILED reply_byte expected none seen %h", drive_master_model_inst.got_byte);
                end else begin
                    last = expq.pop_front();
                    `CHK("reply_byte", last, drive_master_model_inst.got_byte)
                end
                `CHK("parity", 1'b1, drive_master_model_inst.par_ok)
            end
        end
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        seed = lfsr(seed);
        raw_position = seed[26:0];
        exp_pos(8'h40, seed[26:0]);
        run('{8'h40, 8'h42}, 0, -1);
        exp('{8'h40, 8'h52, 8'h5A});
        run('{8'h40, 8'h52}, 0, -1);
        exp('{8'h40, 8'h56, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01});
        run('{8'h40, 8'h56}, 0, -1);
        done("identity");
        exp('{8'h40, 8'h4D});
        run('{8'h40, 8'h4D, 8'h01, 8'h04, 8'h33}, 0, -1);
        exp('{8'h40, 8'h4D});
        run('{8'h40, 8'h4D, 8'h02, 8'h84, 8'h33}, 0, -1);
        exp('{8'h40, 8'h4B});
        run('{8'h40, 8'h4B, 8'h01, 8'h02, 8'h33, 8'hA5}, 0, -1);
        exp('{8'h40, 8'h4A, 8'hA5});
        run('{8'h40, 8'h4A, 8'h01, 8'h02, 8'h33}, 0, -1);
        exp('{8'h40, 8'h4C, 8'h84});
        run('{8'h40, 8'h4C, 8'h02}, 0, -1);
        exp('{8'h40, 8'h4E, 8'h60});
        run('{8'h40, 8'h4E}, 0, -1);
        err('{8'h40, 8'h4B, 8'h02, 8'h00, 8'h33, 8'h00}, 0, -1, 8'h0E);
        err('{8'h40, 8'h4A, 8'h01, 8'h04, 8'h33}, 0, -1, 8'h11);
        err('{8'h40, 8'h4D, 8'h01, 8'h04, 8'h33}, 0, -1, 8'h10);
        done("fields");
        err('{8'h40, 8'h44}, 0, -1, 8'h0B);
        err('{8'h40, 8'h42}, 0, 1, 8'h09);
        err('{8'h40, 8'h42}, 1, -1, 8'h0A);
        err('{8'h40, 8'h42, 8'h00}, 0, -1, 8'h0C);
        err('{8'h40, 8'h43, 8'h00, 8'h00, 8'h00, 8'h05, 8'h54}, 0, -1, 8'h0F);
        err('{8'h40, 8'h4A, 8'h08, 8'h00, 8'h55}, 0, -1, 8'h0D);
        err('{8'h40, 8'h4A, 8'h00, 8'h00, 8'h55}, 0, -1, 8'h12);
        err('{8'h40, 8'h4C, 8'h00}, 0, -1, 8'h12);
        err('{8'h40, 8'h4D, 8'h00, 8'h00, 8'h55}, 0, -1, 8'h0D);
        run('{8'h41, 8'h42}, 0, -1);
        `CHK("fault_code", 8'h0D, fault_code)
        done("errors");
        for (int i = 0; i < 15; i++) begin
            fvec = 15'(1 << i);
            repeat (3) @(negedge core_clk);
            `CHK("fault_code", fcode(i), fault_code)
        end
        fvec = 15'h0;
        repeat (3) @(negedge core_clk);
        `CHK("fault_code", 8'h1E, fault_code)
        exp('{8'h40, 8'h50, 8'h1E});
        run('{8'h40, 8'h50}, 0, -1);
        skip = 1'b1;
        run('{8'h40, 8'h53}, 0, -1);
        skip = 1'b0;
        `CHK("fault_code", 8'h00, fault_code)
        exp('{8'h40, 8'h50, 8'h00});
        run('{8'h40, 8'h50}, 0, -1);
        done("faults");
        seed = lfsr(seed);
        pos = seed[26:0];
        skip = 1'b1;
        run('{8'h40, 8'h43, {5'b0, pos[26:24]}, pos[23:16], pos[15:8], pos[7:0], 8'h55}, 0, -1);
        skip = 1'b0;
        raw_position = raw_position + 27'd5;
        exp_pos(8'h40, pos + 27'd5);
        run('{8'h40, 8'h42}, 0, -1);
        skip = 1'b1;
        run('{8'h40, 8'h55, 8'h41, 8'h55}, 0, -1);
        run('{8'h41, 8'h57, 8'hE5, 8'h55}, 0, -1);
        skip = 1'b0;
        `CHK("node_addr", 8'h41, node_addr)
        `CHK("iface_mode", 8'hE5, iface_mode)
        exp_pos(8'h41, pos + 27'd5);
        run('{8'h41, 8'h42}, 0, -1);
        done("protected");
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        `CHK("node_addr", 8'h40, node_addr)
        `CHK("iface_mode", 8'hE4, iface_mode)
        `CHK("fault_code", 8'h00, fault_code)
        done("reset");
        close_out();
    end
endmodule // test_encoder_parameter_command_unit
